// ---- logic/rotate_exec_pkg.sv ----
package rotate_exec_pkg;
	// ------------------------------------------------------------
	// Widths and address map
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int FILE_ADDR_W = 8;
	localparam int BANK_W = 4;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] FSR2_RESET = 12'h000;
	localparam int MEM_DEPTH = 4096;

	// ------------------------------------------------------------
	// Register bus offsets (byte-less index map, own choice)
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_WORKING = 4'h0;
	localparam logic [3:0] OFF_BANK = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h2;
	localparam logic [3:0] OFF_INDEX_BASE = 4'h3;
	localparam logic [3:0] OFF_CONFIG = 4'h4;
	localparam logic [3:0] OFF_MEM_ADDR = 4'h5;
	localparam logic [3:0] OFF_MEM_DATA = 4'h6;
	localparam logic [3:0] OFF_INSTR = 4'h7;
	localparam int STATUS_CARRY_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;
	localparam int CONFIG_EXT_BIT = 0;

	// ------------------------------------------------------------
	// Instruction word: op(1) d a f(8), own layout
	// ------------------------------------------------------------
	localparam int INSTR_F_LSB = 0;
	localparam int INSTR_A_BIT = 8;
	localparam int INSTR_D_BIT = 9;
	localparam int INSTR_OP_BIT = 10;
	localparam logic OP_RLNC = 1'b0;
	localparam logic OP_RRC = 1'b1;

	typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
endpackage : rotate_exec_pkg

// ---- logic/file_reg_mem.sv ----
`timescale 1ns/1ps
module file_reg_mem
	import rotate_exec_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
)
(
	// Clock
	input wire logic clk,
	input wire logic ce,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
		if (ce)
			rd_data <= mem[rd_addr];
	end
endmodule : file_reg_mem

// ---- logic/rotate_instruction_exec.sv ----
`timescale 1ns/1ps
// Behaviour
// - Rotate right through carry moves bit 0 into carry and old carry into bit 7.
// - Rotate left without carry wraps bit 7 into bit 0 and leaves carry alone.
// - Destination bit 0 writes the working register, 1 writes back the file register.
// - Access bit 1 addresses the bank chosen by the bank select register.
// - Access bit 0 addresses the access bank instead of the bank select register.
// - Access bit 0 with extended set on and address up to 95 uses indexed literal offset.
// - One word, one cycle of decode, read, process and write in the fourth phase.
module rotate_instruction_exec
	import rotate_exec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	phase_t phase_reg;
	phase_t phase_next;
	logic [7:0] working_reg;
	logic [3:0] bank_select_register;
	logic carry_reg;
	logic [11:0] index_base_reg;
	logic ext_enable_reg;
	logic [11:0] mem_addr_reg;
	logic [10:0] instr_reg;
	logic [11:0] eff_addr_reg;
	logic [7:0] result_reg;
	logic carry_out_reg;
	logic [15:0] reg_rdata_reg;
	logic [7:0] mem_rdata;

	// ------------------------------------------------------------
	// Software write decode
	// ------------------------------------------------------------
	// Register index match, shared by every write select
	function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
		addr_hit = (a == off);
	endfunction : addr_hit

	// Writes only land between instructions, so operands stay put mid-flight
	wire logic sw_write = reg_wr && (phase_reg == PH_IDLE);
	wire logic sel_working = sw_write && addr_hit(reg_addr, OFF_WORKING);
	wire logic sel_bank = sw_write && addr_hit(reg_addr, OFF_BANK);
	wire logic sel_status = sw_write && addr_hit(reg_addr, OFF_STATUS);
	wire logic sel_index = sw_write && addr_hit(reg_addr, OFF_INDEX_BASE);
	wire logic sel_config = sw_write && addr_hit(reg_addr, OFF_CONFIG);
	wire logic sel_mem_addr = sw_write && addr_hit(reg_addr, OFF_MEM_ADDR);
	wire logic sel_mem_data = sw_write && addr_hit(reg_addr, OFF_MEM_DATA);
	wire logic sel_instr = sw_write && addr_hit(reg_addr, OFF_INSTR);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic [7:0] f_field = instr_reg[INSTR_F_LSB +: FILE_ADDR_W];
	wire logic access_bit = instr_reg[INSTR_A_BIT];
	wire logic dest_bit = instr_reg[INSTR_D_BIT];
	wire logic op_bit = instr_reg[INSTR_OP_BIT];
	wire logic indexed_mode = !access_bit && ext_enable_reg && (f_field <= INDEXED_LIMIT);
	wire logic [11:0] indexed_addr = index_base_reg + {4'h0, f_field};
	wire logic [3:0] access_bank = (f_field < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
	wire logic [11:0] banked_addr = {bank_select_register, f_field};
	wire logic [11:0] eff_addr = indexed_mode ? indexed_addr
		: (access_bit ? banked_addr : {access_bank, f_field});
	wire logic start = sel_instr;
	wire logic mem_write_sw = sel_mem_data;
	wire logic exec_write = (phase_reg == PH_WRITE);
	wire logic file_write = exec_write && dest_bit;
	// Read phase needs the live address; the registered copy only loads at its end
	wire logic [11:0] rd_addr = (phase_reg == PH_READ) ? eff_addr : mem_addr_reg;

	// Rotations; carry only changes for the right rotate
	function automatic logic [8:0] rotate(input logic op, input logic [7:0] v, input logic c);
		if (op == OP_RRC)
			rotate = {v[0], c, v[7:1]};
		else
			rotate = {c, v[6:0], v[7]};
	endfunction : rotate

	wire logic [8:0] rot = rotate(op_bit, mem_rdata, carry_reg);

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_IDLE: if (start) phase_next = PH_READ;
			PH_READ: phase_next = PH_PROCESS;
			PH_PROCESS: phase_next = PH_WRITE;
			PH_WRITE: phase_next = PH_IDLE;
			default: phase_next = PH_IDLE;
		endcase
	end

	file_reg_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
		.clk(clk),
		.ce(ce),
		.wr_en(file_write || mem_write_sw),
		.wr_addr(file_write ? eff_addr_reg : mem_addr_reg),
		.wr_data(file_write ? result_reg : reg_wdata[7:0]),
		.rd_addr(rd_addr),
		.rd_data(mem_rdata)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			phase_reg <= PH_IDLE;
			instr_reg <= 11'h000;
			eff_addr_reg <= FSR2_RESET;
			result_reg <= DATA_RESET;
			carry_out_reg <= 1'b0;
		end
		else if (ce)
		begin
			phase_reg <= phase_next;
			if (start)
				instr_reg <= reg_wdata[10:0];
			if (phase_reg == PH_READ)
				eff_addr_reg <= eff_addr;
			if (phase_reg == PH_PROCESS)
			begin
				result_reg <= rot[7:0];
				carry_out_reg <= rot[8];
			end
		end
	end

	// Working register and carry: the write phase owns them while busy
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			working_reg <= DATA_RESET;
			carry_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (exec_write)
			begin
				carry_reg <= carry_out_reg;
				if (!dest_bit)
					working_reg <= result_reg;
			end
			else
			begin
				if (sel_working)
					working_reg <= reg_wdata[7:0];
				if (sel_status)
					carry_reg <= reg_wdata[STATUS_CARRY_BIT];
			end
		end
	end

	// Addressing setup, changed by software only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			bank_select_register <= BANK_RESET;
			index_base_reg <= FSR2_RESET;
			ext_enable_reg <= 1'b0;
			mem_addr_reg <= FSR2_RESET;
		end
		else if (ce)
		begin
			if (sel_bank)
				bank_select_register <= reg_wdata[3:0];
			if (sel_index)
				index_base_reg <= reg_wdata[11:0];
			if (sel_config)
				ext_enable_reg <= reg_wdata[CONFIG_EXT_BIT];
			if (sel_mem_addr)
				mem_addr_reg <= reg_wdata[11:0];
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	wire logic [15:0] status_word = {14'h0000, phase_reg != PH_IDLE, carry_reg};
	wire logic [15:0] rd_mux = (reg_addr == OFF_WORKING) ? {8'h00, working_reg}
		: (reg_addr == OFF_BANK) ? {12'h000, bank_select_register}
		: (reg_addr == OFF_STATUS) ? status_word
		: (reg_addr == OFF_INDEX_BASE) ? {4'h0, index_base_reg}
		: (reg_addr == OFF_CONFIG) ? {15'h0000, ext_enable_reg}
		: (reg_addr == OFF_MEM_ADDR) ? {4'h0, mem_addr_reg}
		: (reg_addr == OFF_INSTR) ? {5'h00, instr_reg}
		: 16'h0000;
	logic rd_mem_reg;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			reg_rdata_reg <= 16'h0000;
			rd_mem_reg <= 1'b0;
		end
		else if (ce)
		begin
			reg_rdata_reg <= reg_rd ? rd_mux : 16'h0000;
			rd_mem_reg <= reg_rd && (reg_addr == OFF_MEM_DATA);
		end
	end

	// Memory data comes straight from the memory's output register
	assign reg_rdata = rd_mem_reg ? {8'h00, mem_rdata} : reg_rdata_reg;
endmodule : rotate_instruction_exec

// ---- tb/rotate_exec_properties.sv ----
`timescale 1ns/1ps
module rotate_exec_properties
	import rotate_exec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_rdata_idle_zero: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not cleared");
	a_freeze_rdata: assert property (!ce |=> $stable(reg_rdata))
		else $error("read data moved while frozen");
	a_busy_raised: assert property (ce && reg_wr && reg_addr == OFF_INSTR ##1 ce
		##1 ce && reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[STATUS_BUSY_BIT])
		else $error("busy not set");
	a_busy_done: assert property (ce && reg_wr && reg_addr == OFF_INSTR ##1 ce[*4]
		##1 ce && reg_rd && reg_addr == OFF_STATUS |=> !reg_rdata[STATUS_BUSY_BIT])
		else $error("busy too long");
	a_status_width: assert property (ce && reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[15:2] == 14'h0000)
		else $error("status upper bits set");
	a_working_width: assert property (ce && reg_rd && reg_addr == OFF_WORKING |=> reg_rdata[15:8] == 8'h00)
		else $error("working upper bits set");
	a_file_width: assert property (ce && reg_rd && reg_addr == OFF_MEM_DATA |=> reg_rdata[15:8] == 8'h00)
		else $error("file data upper bits set");
endmodule : rotate_exec_properties

bind rotate_instruction_exec rotate_exec_properties i_props (.clk(clk), .srst(srst), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import rotate_exec_pkg::*;
	typedef struct {logic op, d, a, x, c; logic [7:0] f; logic [11:0] m; logic [7:0] v, r; logic co;} row_t;
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
	int failures = 0, n_compared = 0;
	// Bank 3 and index base 0x200 are set once before the rows
	row_t rows [7] = '{
		'{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h20, 12'h020, 8'hab, 8'h57, 1'b0},
		'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h20, 12'h020, 8'he6, 8'h73, 1'b0},
		'{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h41, 12'h341, 8'h01, 8'h80, 1'b1},
		'{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'hff, 12'h3ff, 8'h80, 8'h01, 1'b1},
		'{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h80, 12'hf80, 8'h02, 8'h81, 1'b0},
		'{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h5f, 12'h25f, 8'h81, 8'h03, 1'b0},
		'{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h60, 12'hf60, 8'h55, 8'h2a, 1'b1}
	};

	always #10 clk = ~clk;

	rotate_instruction_exec i_dut (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task chk(input string s, input logic [15:0] e);
		n_compared++;
		if (v !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", s, e, v);
		end
	endtask : chk

	task complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// Whole run is a few hundred cycles
	initial
	begin
		#100000;
		failures++;
		complete_run();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wr(OFF_BANK, 16'h0003);
		wr(OFF_INDEX_BASE, 16'h0200);
		foreach (rows[i])
		begin
			wr(OFF_CONFIG, {15'h0000, rows[i].x});
			wr(OFF_STATUS, {15'h0000, rows[i].c});
			wr(OFF_WORKING, 16'h005a);
			wr(OFF_MEM_ADDR, {4'h0, rows[i].m});
			wr(OFF_MEM_DATA, {8'h00, rows[i].v});
			wr(OFF_INSTR, {5'h00, rows[i].op, rows[i].d, rows[i].a, rows[i].f});
			repeat (3) @(posedge clk);
			rd(OFF_STATUS);
			chk("carry", {15'h0000, rows[i].co});
			rd(OFF_WORKING);
			chk("working", {8'h00, rows[i].d ? 8'h5a : rows[i].r});
			wr(OFF_MEM_ADDR, {4'h0, rows[i].m});
			rd(OFF_MEM_DATA);
			chk("file", {8'h00, rows[i].d ? rows[i].r : rows[i].v});
		end
		// Busy seen mid-instruction, carry still old
		wr(OFF_INSTR, 16'h0341);
		rd(OFF_STATUS);
		chk("busy", 16'h0003);
		repeat (4) @(posedge clk);
		// Freeze stretches this instruction, so the working write below is refused
		wr(OFF_INSTR, 16'h0541);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		wr(OFF_WORKING, 16'h0011);
		repeat (4) @(posedge clk);
		rd(OFF_WORKING);
		chk("refused", 16'h0080);
		// A second instruction written while busy is dropped
		wr(OFF_INSTR, 16'h0141);
		wr(OFF_INSTR, 16'h0541);
		repeat (2) @(posedge clk);
		rd(OFF_WORKING);
		chk("busy instr", 16'h0002);
		rd(OFF_STATUS);
		chk("busy carry", 16'h0001);
		// Mid-run reset clears the software registers
		wr(OFF_BANK, 16'h0005);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_BANK);
		chk("reset bank", 16'h0000);
		rd(OFF_WORKING);
		chk("reset working", 16'h0000);
		rd(OFF_STATUS);
		chk("reset status", 16'h0000);
		complete_run();
	end
endmodule : tb_top
